/* rtl/sasc_top.sv */
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
//Operation
// - self-test query always answers 1.
// - abort character flushes output buffer; status registers untouched.
// - reset command acts as power cycle; status cleared per power-on setting.
// - local command and power-up enable all front-panel controls.
// - remote locks panel; local, reset, shift-menu or power unlock.
// - remote lockout shows the remote mark below the ramping mark.
// - time is month/day/year and 24-hour hours:minutes:seconds.
// - up to ten errors held, oldest returned first.
// - errors removed when read; clear-status or power cycle empties all.
// - status byte query returns it and leaves bit 6 alone.
// - service enable mask picks bits for bit 6; readback; 4 is quench.
// - clear-status clears event register and error buffer together.
// - event query returns standard event register.
// - event enable mask feeds bit 5; readback; 60 all errors.
// - power-on clear setting 1 clears masks, 0 keeps; default 1.
// - operation-complete command sets event bit 0 when executed.
// - operation-complete query answers 1 to its source only.
// - identification answers model number and firmware revision.
// - output range query returns 0..5, read-only remotely.
// - supply type query returns 0..17, read-only remotely.
// - field-unit commands need a positive non-zero field ratio.
// - current cap limits magnitude, both polarities, every mode.
// - reading the event register also clears it.
// - queue holds four; overflow discards and logs error -303.
// - event bits 0,2,3,4,5,7 defined; bits 1 and 6 zero.
module sasc_top #(
	parameter longint SEC_CYCLES = sasc_pkg::SEC_CYCLES
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic [7:0] status_in,
	input wire logic quench_in,
	input wire logic err_push,
	input wire logic signed [15:0] err_code,
	input wire logic [2:0] range_pin,
	input wire logic [4:0] supply_type_pin,
	input wire logic shift_menu_pin,
	input wire logic signed [31:0] current_req,
	output logic signed [31:0] current_cmd,
	output logic panel_lock,
	output logic remote_mark,
	output logic [7:0] stb
);
	// ==========================================================
	// helpers
	function automatic logic is_query(input logic [7:0] op);
		case (op)
		sasc_pkg::OP_IDN, sasc_pkg::OP_TST, sasc_pkg::OP_TIME_Q,
		sasc_pkg::OP_ERR_Q, sasc_pkg::OP_STB_Q, sasc_pkg::OP_SRE_Q,
		sasc_pkg::OP_ESR_Q, sasc_pkg::OP_ESE_Q, sasc_pkg::OP_PSC_Q,
		sasc_pkg::OP_OPC_Q, sasc_pkg::OP_MODE_Q, sasc_pkg::OP_TYPE_Q,
		sasc_pkg::OP_RATIO_Q, sasc_pkg::OP_FIELD_Q,
		sasc_pkg::OP_CAP_Q:
			is_query = 1'b1;
		default:
			is_query = 1'b0;
		endcase
	endfunction

	// maps an error code to its standard event category bit
	function automatic logic [7:0] err_class(input logic signed [15:0] c);
		err_class = 8'h00;
		if (c <= -16'sd100 && c > -16'sd200)
			err_class[sasc_pkg::ESR_CMD] = 1'b1;
		else if (c <= -16'sd200 && c > -16'sd300)
			err_class[sasc_pkg::ESR_QUERY] = 1'b1;
		else if (c <= -16'sd300 && c > -16'sd400)
			err_class[sasc_pkg::ESR_EXEC] = 1'b1;
		else if (c <= -16'sd400)
			err_class[sasc_pkg::ESR_DEVICE] = 1'b1;
	endfunction

	function automatic logic [4:0] month_days(input logic [3:0] m,
			input logic [15:0] y);
		case (m)
		4'h2:
			month_days = (y[1:0] & sasc_pkg::LEAP_MASK) == 2'h0 ?
				5'd29 : 5'd28;
		4'h4, 4'h6, 4'h9, 4'hb:
			month_days = 5'd30;
		default:
			month_days = 5'd31;
		endcase
	endfunction

	// ==========================================================
	// pin synchronisers
	logic [2:0] range_s1, range_s2;
	logic [4:0] type_s1, type_s2;
	logic menu_s1, menu_s2, menu_d;
	always_ff @(posedge clk_sys) begin
		range_s1 <= range_pin;
		range_s2 <= range_s1;
		type_s1 <= supply_type_pin;
		type_s2 <= type_s1;
		menu_s1 <= shift_menu_pin;
		menu_s2 <= menu_s1;
		menu_d <= menu_s2;
	end
	wire menu_rise = menu_s2 && !menu_d;

	// ==========================================================
	// command queue, four entries of source, opcode and argument
	logic [40:0] q_mem [sasc_pkg::QUEUE_DEPTH];
	logic [1:0] q_rd, q_wr;
	logic [2:0] q_cnt;
	logic [31:0] arg_stage;
	logic [31:0] date_stage;
	logic [1:0] resp_valid;
	logic [31:0] resp [2];
	logic do_exec, q_push, q_full, flush;
	logic ex_src;
	logic [7:0] ex_op;
	logic [31:0] ex_arg;

	assign q_full = q_cnt == 3'(sasc_pkg::QUEUE_DEPTH);
	assign q_push = wr && addr == sasc_pkg::REG_CMD && !q_full;
	assign {ex_src, ex_op, ex_arg} = q_mem[q_rd];
	// a query waits while its interface still holds an unread answer
	assign do_exec = q_cnt != 3'h0 &&
		!(is_query(ex_op) && resp_valid[ex_src]);
	assign flush = do_exec && ex_op == sasc_pkg::OP_RST;

	// queue pointers; the reset command drops what follows it
	always_ff @(posedge clk_sys) begin
		if (reset || flush) begin
			q_rd <= 2'h0;
			q_wr <= 2'h0;
			q_cnt <= 3'h0;
		end else begin
			if (q_push)
				q_wr <= q_wr + 2'h1;
			if (do_exec)
				q_rd <= q_rd + 2'h1;
			q_cnt <= q_cnt + (q_push ? 3'h1 : 3'h0)
				- (do_exec ? 3'h1 : 3'h0);
		end
	end

	// queue storage and argument staging
	always_ff @(posedge clk_sys) begin
		if (q_push)
			q_mem[q_wr] <= {wdata[sasc_pkg::CMD_SRC_BIT],
				wdata[7:0], arg_stage};
		if (reset)
			arg_stage <= 32'h0000_0000;
		else if (wr && addr == sasc_pkg::REG_ARG)
			arg_stage <= wdata;
		if (reset)
			date_stage <= 32'h0000_0000;
		else if (wr && addr == sasc_pkg::REG_DATE)
			date_stage <= wdata;
	end

	// ==========================================================
	// decoded command effects
	wire ex_cls = do_exec && ex_op == sasc_pkg::OP_CLS;
	wire ex_esr_q = do_exec && ex_op == sasc_pkg::OP_ESR_Q;
	wire ex_err_q = do_exec && ex_op == sasc_pkg::OP_ERR_Q;
	logic signed [31:0] ratio;
	logic [31:0] cap;
	logic [31:0] field_target;
	logic field_bad, undef;
	assign field_bad = do_exec && (ex_op == sasc_pkg::OP_FIELD_SET ||
		ex_op == sasc_pkg::OP_FIELD_Q) && ratio <= 32'sd0;
	assign undef = do_exec && !is_query(ex_op) && !(
		ex_op inside {sasc_pkg::OP_RST, sasc_pkg::OP_LOCAL,
		sasc_pkg::OP_REMOTE, sasc_pkg::OP_TIME_SET, sasc_pkg::OP_SRE_SET,
		sasc_pkg::OP_CLS, sasc_pkg::OP_ESE_SET, sasc_pkg::OP_PSC_SET,
		sasc_pkg::OP_OPC, sasc_pkg::OP_RATIO_SET, sasc_pkg::OP_FIELD_SET,
		sasc_pkg::OP_CAP_SET});

	// ==========================================================
	// error buffer; overflow wins over execution errors, then pins
	logic signed [15:0] err_head;
	logic [3:0] err_cnt;
	logic ovf;
	logic fifo_push;
	logic signed [15:0] fifo_code;
	assign ovf = wr && addr == sasc_pkg::REG_CMD && q_full;
	always_comb begin
		fifo_push = 1'b1;
		if (ovf)
			fifo_code = sasc_pkg::ERR_OVERFLOW;
		else if (undef)
			fifo_code = sasc_pkg::ERR_UNDEF;
		else if (field_bad)
			fifo_code = sasc_pkg::ERR_CONFLICT;
		else begin
			fifo_code = err_code;
			fifo_push = err_push;
		end
	end

	sasc_err_fifo u_err (
		.clk_sys(clk_sys),
		.reset(reset),
		.clear(ex_cls || flush),
		.push(fifo_push),
		.push_code(fifo_code),
		.pop(ex_err_q),
		.head_code(err_head),
		.count(err_cnt)
	);

	// ==========================================================
	// standard event register; a new event beats a clear
	logic [7:0] esr, esr_set;
	always_comb begin
		esr_set = 8'h00;
		if (ovf)
			esr_set = esr_set | err_class(sasc_pkg::ERR_OVERFLOW);
		if (undef)
			esr_set = esr_set | err_class(sasc_pkg::ERR_UNDEF);
		if (field_bad)
			esr_set = esr_set | err_class(sasc_pkg::ERR_CONFLICT);
		if (err_push)
			esr_set = esr_set | err_class(err_code);
		if (do_exec && ex_op == sasc_pkg::OP_OPC)
			esr_set[sasc_pkg::ESR_OPC] = 1'b1;
		if (flush)
			esr_set[sasc_pkg::ESR_PON] = 1'b1;
	end
	always_ff @(posedge clk_sys) begin
		if (reset)
			esr <= 8'h00 | (8'h01 << sasc_pkg::ESR_PON);
		else if (ex_cls || ex_esr_q)
			esr <= esr_set & sasc_pkg::ESR_USED;
		else
			esr <= (esr | esr_set) & sasc_pkg::ESR_USED;
	end

	// ==========================================================
	// enable masks and power-on clear setting
	logic [7:0] sre, ese;
	logic psc;
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			psc <= sasc_pkg::PSC_RESET;
			sre <= 8'h00;
			ese <= 8'h00;
		end else if (flush) begin
			if (psc) begin
				sre <= 8'h00;
				ese <= 8'h00;
			end
		end else if (do_exec) begin
			if (ex_op == sasc_pkg::OP_SRE_SET)
				sre <= ex_arg[7:0];
			if (ex_op == sasc_pkg::OP_ESE_SET)
				ese <= ex_arg[7:0];
			if (ex_op == sasc_pkg::OP_PSC_SET)
				psc <= ex_arg[0];
		end
	end

	// status byte, refreshed every cycle and never cleared by a read
	logic [7:0] next_stb;
	always_comb begin
		next_stb = status_in & sasc_pkg::STB_EXT;
		next_stb[sasc_pkg::STB_QUENCH] = quench_in;
		next_stb[sasc_pkg::STB_ESB] = |(esr & ese);
		next_stb[sasc_pkg::STB_MSS] = |(next_stb & sre &
			~(8'h01 << sasc_pkg::STB_MSS));
	end
	always_ff @(posedge clk_sys) begin
		if (reset)
			stb <= 8'h00;
		else
			stb <= next_stb;
	end

	// ==========================================================
	// front panel lockout
	always_ff @(posedge clk_sys) begin
		if (reset || flush || menu_rise) begin
			panel_lock <= 1'b0;
			remote_mark <= 1'b0;
		end else if (do_exec && ex_op == sasc_pkg::OP_LOCAL) begin
			panel_lock <= 1'b0;
			remote_mark <= 1'b0;
		end else if (do_exec && ex_op == sasc_pkg::OP_REMOTE) begin
			panel_lock <= 1'b1;
			remote_mark <= 1'b1;
		end
	end

	// ==========================================================
	// real-time clock, one-second enable from a divider
	logic [31:0] div;
	logic sec_tick;
	logic [5:0] t_sec, t_min;
	logic [4:0] t_hour, t_day;
	logic [3:0] t_mon;
	logic [15:0] t_year;
	assign sec_tick = div == 32'(SEC_CYCLES - 1);
	always_ff @(posedge clk_sys) begin
		if (reset || sec_tick)
			div <= 32'h0000_0000;
		else
			div <= div + 32'h1;
	end
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			{t_hour, t_min, t_sec} <= 17'h00000;
			t_day <= 5'h01;
			t_mon <= 4'h1;
			t_year <= sasc_pkg::YEAR_RESET;
		end else if (do_exec && ex_op == sasc_pkg::OP_TIME_SET) begin
			t_sec <= ex_arg[sasc_pkg::SEC_LSB +: 6];
			t_min <= ex_arg[sasc_pkg::MIN_LSB +: 6];
			t_hour <= ex_arg[sasc_pkg::HOUR_LSB +: 5];
			t_year <= date_stage[sasc_pkg::YEAR_LSB +: 16];
			t_day <= date_stage[sasc_pkg::DAY_LSB +: 5];
			t_mon <= date_stage[sasc_pkg::MON_LSB +: 4];
		end else if (sec_tick) begin
			// cascade of rollovers, hours wrap at 24
			t_sec <= t_sec + 6'h1;
			if (t_sec == sasc_pkg::SIXTY - 6'h1) begin
				t_sec <= 6'h00;
				t_min <= t_min + 6'h1;
				if (t_min == sasc_pkg::SIXTY - 6'h1) begin
					t_min <= 6'h00;
					t_hour <= t_hour + 5'h1;
					if (t_hour == sasc_pkg::HOURS_DAY - 5'h1) begin
						t_hour <= 5'h00;
						t_day <= t_day + 5'h1;
						if (t_day == month_days(t_mon, t_year)) begin
							t_day <= 5'h01;
							t_mon <= t_mon + 4'h1;
							if (t_mon == sasc_pkg::MONTHS) begin
								t_mon <= 4'h1;
								t_year <= t_year + 16'h1;
							end
						end
					end
				end
			end
		end
	end

	// ==========================================================
	// field ratio, field target and current cap
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ratio <= 32'sh0000_0000;
			cap <= 32'h0000_0000;
			field_target <= 32'h0000_0000;
		end else if (do_exec) begin
			if (ex_op == sasc_pkg::OP_RATIO_SET)
				ratio <= ex_arg;
			if (ex_op == sasc_pkg::OP_CAP_SET)
				cap <= ex_arg;
			if (ex_op == sasc_pkg::OP_FIELD_SET && !field_bad)
				field_target <= ex_arg;
		end
	end
	// one magnitude serves both polarities
	always_ff @(posedge clk_sys) begin
		if (reset)
			current_cmd <= 32'sh0000_0000;
		else if (current_req > $signed(cap))
			current_cmd <= $signed(cap);
		else if (current_req < -$signed(cap))
			current_cmd <= -$signed(cap);
		else
			current_cmd <= current_req;
	end

	// ==========================================================
	// answers, one slot for each interface
	logic [31:0] answer;
	logic [31:0] date_snap;
	always_comb begin
		case (ex_op)
		sasc_pkg::OP_IDN:
			answer = {sasc_pkg::MODEL_CODE, sasc_pkg::FW_REV};
		sasc_pkg::OP_TST, sasc_pkg::OP_OPC_Q:
			answer = 32'(sasc_pkg::ANSWER_ONE);
		sasc_pkg::OP_TIME_Q:
			answer = 32'({t_hour, t_min, t_sec});
		sasc_pkg::OP_ERR_Q:
			answer = 32'(err_head);
		sasc_pkg::OP_STB_Q:
			answer = 32'(stb);
		sasc_pkg::OP_SRE_Q:
			answer = 32'(sre);
		sasc_pkg::OP_ESR_Q:
			answer = 32'(esr);
		sasc_pkg::OP_ESE_Q:
			answer = 32'(ese);
		sasc_pkg::OP_PSC_Q:
			answer = 32'(psc);
		sasc_pkg::OP_MODE_Q:
			answer = 32'(range_s2);
		sasc_pkg::OP_TYPE_Q:
			answer = 32'(type_s2);
		sasc_pkg::OP_RATIO_Q:
			answer = ratio;
		sasc_pkg::OP_FIELD_Q:
			answer = field_target;
		sasc_pkg::OP_CAP_Q:
			answer = cap;
		default:
			answer = 32'h0000_0000;
		endcase
	end

	// a read pops a slot; the abort character empties one slot only
	wire rd_r0 = rd && addr == sasc_pkg::REG_RESP0;
	wire rd_r1 = rd && addr == sasc_pkg::REG_RESP1;
	wire etx = wr && addr == sasc_pkg::REG_ABORT &&
		wdata[7:0] == sasc_pkg::ETX_CODE;
	wire [1:0] etx_sel = etx ? (wdata[sasc_pkg::CMD_SRC_BIT] ?
		2'b10 : 2'b01) : 2'b00;
	wire ans = do_exec && is_query(ex_op) && !field_bad;
	always_ff @(posedge clk_sys) begin
		if (reset || flush) begin
			resp_valid <= 2'b00;
		end else begin
			resp_valid <= resp_valid & ~{rd_r1, rd_r0} & ~etx_sel;
			if (ans)
				resp_valid[ex_src] <= 1'b1;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			resp[0] <= 32'h0000_0000;
			resp[1] <= 32'h0000_0000;
			date_snap <= 32'h0000_0000;
		end else if (ans) begin
			resp[ex_src] <= answer;
			if (ex_op == sasc_pkg::OP_TIME_Q)
				date_snap <= 32'({t_mon, 3'h0, t_day, t_year});
		end
	end

	// ==========================================================
	// register read port, data one cycle after the strobe
	always_ff @(posedge clk_sys) begin
		if (reset)
			rdata <= 32'h0000_0000;
		else if (!rd)
			rdata <= 32'h0000_0000;
		else if (addr == sasc_pkg::REG_RESP0)
			rdata <= resp[0];
		else if (addr == sasc_pkg::REG_RESP1)
			rdata <= resp[1];
		else if (addr == sasc_pkg::REG_STATUS)
			rdata <= {16'h0000, err_cnt, 1'b0, q_cnt,
				5'h00, panel_lock, resp_valid};
		else if (addr == sasc_pkg::REG_DATE)
			rdata <= date_snap;
		else if (addr == sasc_pkg::REG_STB)
			rdata <= 32'(stb);
		else if (addr == sasc_pkg::REG_ARG)
			rdata <= arg_stage;
		else
			rdata <= 32'h0000_0000;
	end
endmodule

/* include/sasc_pkg.sv */
package sasc_pkg;
	// ==========================================================
	// bus and clock
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam longint CLK_HZ = 100_000_000;
	localparam longint TICK_S = 1; // time step of the clock, seconds
	localparam longint SEC_CYCLES = CLK_HZ * TICK_S;

	// ==========================================================
	// register byte addresses
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_ARG = 8'h04;
	localparam logic [7:0] REG_ABORT = 8'h08;
	localparam logic [7:0] REG_RESP0 = 8'h0c;
	localparam logic [7:0] REG_RESP1 = 8'h10;
	localparam logic [7:0] REG_STATUS = 8'h14;
	localparam logic [7:0] REG_DATE = 8'h18;
	localparam logic [7:0] REG_STB = 8'h1c;
	localparam int CMD_SRC_BIT = 8; // interface that sent the command
	localparam logic [7:0] ETX_CODE = 8'h03; // abort character

	// ==========================================================
	// command opcodes
	typedef enum logic [7:0] {
		OP_IDN = 8'h01, OP_RST = 8'h02, OP_TST = 8'h03,
		OP_LOCAL = 8'h04, OP_REMOTE = 8'h05, OP_TIME_Q = 8'h06,
		OP_TIME_SET = 8'h07, OP_ERR_Q = 8'h08, OP_STB_Q = 8'h09,
		OP_SRE_SET = 8'h0a, OP_SRE_Q = 8'h0b, OP_CLS = 8'h0c,
		OP_ESR_Q = 8'h0d, OP_ESE_SET = 8'h0e, OP_ESE_Q = 8'h0f,
		OP_PSC_SET = 8'h10, OP_PSC_Q = 8'h11, OP_OPC = 8'h12,
		OP_OPC_Q = 8'h13, OP_MODE_Q = 8'h14, OP_TYPE_Q = 8'h15,
		OP_RATIO_SET = 8'h16, OP_RATIO_Q = 8'h17,
		OP_FIELD_SET = 8'h18, OP_FIELD_Q = 8'h19,
		OP_CAP_SET = 8'h1a, OP_CAP_Q = 8'h1b
	} sasc_op_t;

	// ==========================================================
	// standard event and status byte bits
	localparam int ESR_OPC = 0;
	localparam int ESR_QUERY = 2;
	localparam int ESR_DEVICE = 3;
	localparam int ESR_EXEC = 4;
	localparam int ESR_CMD = 5;
	localparam int ESR_PON = 7;
	localparam logic [7:0] ESR_USED = 8'hbd; // bits 1 and 6 read zero
	localparam int STB_QUENCH = 2;
	localparam int STB_ESB = 5;
	localparam int STB_MSS = 6;
	localparam logic [7:0] STB_EXT = 8'h9b; // bits fed by instrument
	localparam logic PSC_RESET = 1'b1;
	localparam logic [7:0] ANSWER_ONE = 8'h01;

	// ==========================================================
	// error codes and buffer sizes
	localparam logic signed [15:0] ERR_OVERFLOW = -16'sd303;
	localparam logic signed [15:0] ERR_UNDEF = -16'sd113;
	localparam logic signed [15:0] ERR_CONFLICT = -16'sd221;
	localparam int QUEUE_DEPTH = 4;
	localparam int ERR_DEPTH = 10;

	// ==========================================================
	// time and date field layout
	localparam int SEC_LSB = 0;
	localparam int MIN_LSB = 6;
	localparam int HOUR_LSB = 12;
	localparam int YEAR_LSB = 0;
	localparam int DAY_LSB = 16;
	localparam int MON_LSB = 24;
	localparam logic [4:0] HOURS_DAY = 5'd24;
	localparam logic [5:0] SIXTY = 6'd60;
	localparam logic [3:0] MONTHS = 4'd12;
	localparam logic [15:0] YEAR_RESET = 16'd2000;
	localparam logic [1:0] LEAP_MASK = 2'h3;

	// ==========================================================
	// identity, values are arbitrary
	localparam logic [15:0] MODEL_CODE = 16'h0a5c;
	localparam logic [15:0] FW_REV = 16'h0100;
endpackage

/* rtl/sasc_err_fifo.sv */
`timescale 1ns/1ps
module sasc_err_fifo (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic clear,
	input wire logic push,
	input wire logic signed [15:0] push_code,
	input wire logic pop,
	output logic signed [15:0] head_code,
	output logic [3:0] count
);
	// ==========================================================
	// ten-entry error store, oldest first
	logic signed [15:0] mem [sasc_pkg::ERR_DEPTH];
	logic [3:0] rd_ptr;
	logic [3:0] wr_ptr;
	logic do_pop;
	logic do_push;

	function automatic logic [3:0] inc(input logic [3:0] p);
		inc = (p == 4'(sasc_pkg::ERR_DEPTH - 1)) ? 4'h0 : p + 4'h1;
	endfunction

	assign do_pop = pop && (count != 4'h0);
	// a full buffer drops the newest error rather than the oldest
	assign do_push = push && (count != 4'(sasc_pkg::ERR_DEPTH));
	assign head_code = (count == 4'h0) ? 16'sh0000 : mem[rd_ptr];

	// pointers; an error arriving with a clear is kept
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rd_ptr <= 4'h0;
			wr_ptr <= 4'h0;
			count <= 4'h0;
		end else if (clear) begin
			rd_ptr <= 4'h0;
			wr_ptr <= push ? 4'h1 : 4'h0;
			count <= push ? 4'h1 : 4'h0;
		end else begin
			if (do_pop)
				rd_ptr <= inc(rd_ptr);
			if (do_push)
				wr_ptr <= inc(wr_ptr);
			count <= count + (do_push ? 4'h1 : 4'h0)
				- (do_pop ? 4'h1 : 4'h0);
		end
	end

	// storage
	always_ff @(posedge clk_sys) begin
		if (clear && push)
			mem[0] <= push_code;
		else if (!clear && do_push)
			mem[wr_ptr] <= push_code;
	end
endmodule

/* sim/sasc_host.sv */
`timescale 1ns/1ps
// ==========
// host side: register master that carries the command traffic
module sasc_host (
	input wire logic clk_sys,
	output logic [7:0] addr,
	output logic [31:0] wdata,
	output logic wr,
	output logic rd,
	input wire logic [31:0] rdata
);
	// bus idle at time zero
	initial begin
		addr = 8'hff;
		wdata = 32'h0;
		wr = 1'b0;
		rd = 1'b0;
	end
	// one strobe cycle then an idle cycle, so no strobe is set twice
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= !w;
		@(posedge clk_sys);
		wr <= 1'b0;
		rd <= 1'b0;
		addr <= ~a; // released lines show no stale value
		wdata <= ~d;
		#1 q = rdata;
		@(posedge clk_sys);
	endtask
	// staged argument, then opcode; the source bit picks the answer slot
	task automatic cmd(input logic [7:0] op, input logic s,
		input logic [31:0] arg);
		logic [31:0] q;
		xfer(1'b1, sasc_pkg::REG_ARG, arg, q);
		xfer(1'b1, sasc_pkg::REG_CMD, {23'h0, s, op}, q);
	endtask
	// waits for the answer under a bound, then pops it
	task automatic ask(input logic [7:0] op, input logic s,
		input logic [31:0] arg, output logic [31:0] q, output bit ok);
		cmd(op, s, arg);
		ok = 1'b0;
		for (int i = 0; i < 20 && !ok; i++) begin
			xfer(1'b0, sasc_pkg::REG_STATUS, 32'h0, q);
			ok = (q[s] === 1'b1);
		end
		xfer(1'b0, s ? sasc_pkg::REG_RESP1 : sasc_pkg::REG_RESP0, 32'h0, q);
	endtask
endmodule

/* sim/sasc_checker.sv */
`timescale 1ns/1ps
// ==========
// port watch of the command block
module sasc_checker #(
	parameter longint SEC_CYCLES = 100
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [7:0] addr,
	input wire logic rd,
	input wire logic quench_in,
	input wire logic shift_menu_pin,
	input wire logic [31:0] rdata,
	input wire logic signed [31:0] current_req,
	input wire logic signed [31:0] current_cmd,
	input wire logic panel_lock,
	input wire logic remote_mark,
	input wire logic [7:0] stb
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	a_mark_lock: assert property (remote_mark == panel_lock)
		else $error("mark and lock differ");
	a_power_up: assert property (disable iff (1'b0)
		reset |=> !panel_lock && current_cmd == 0) else $error("reset");
	a_shift_unlock: assert property ($rose(shift_menu_pin)
		|-> ##[1:6] !panel_lock) else $error("panel stays locked");
	a_lock_read: assert property (rd && addr == sasc_pkg::REG_STATUS
		|=> rdata[2] == $past(panel_lock)) else $error("lock readback");
	a_quench_bit: assert property (quench_in [*3] |-> stb[2])
		else $error("quench missing");
	a_summary_cause: assert property (stb[6] |-> (stb & 8'hbf) != 0)
		else $error("summary without cause");
	a_clamp_pos: assert property ($past(current_req) >= 0
		|-> current_cmd >= 0 && current_cmd <= $past(current_req))
		else $error("positive clamp");
	a_clamp_neg: assert property ($past(current_req) < 0
		|-> current_cmd <= 0 && current_cmd >= $past(current_req))
		else $error("negative clamp");
	c_unlock: cover property (panel_lock ##1 !panel_lock);
	c_summary: cover property (stb[6]);
	c_clamp: cover property (current_cmd != $past(current_req));
endmodule
bind sasc_top sasc_checker #(.SEC_CYCLES(SEC_CYCLES)) u_sasc_checker (
	.clk_sys(clk_sys), .reset(reset), .addr(addr), .rd(rd),
	.quench_in(quench_in), .shift_menu_pin(shift_menu_pin),
	.rdata(rdata), .current_req(current_req), .current_cmd(current_cmd),
	.panel_lock(panel_lock), .remote_mark(remote_mark), .stb(stb));

/* sim/test_status_and_system_commands.sv */
`timescale 1ns/1ps
// ==========
// bench: command table first, awkward cases after it
module test_status_and_system_commands;
	typedef struct {logic [7:0] op; logic s; logic [31:0] arg;
		logic ans; logic [31:0] exp;} sasc_row_t;
	logic clk_sys, reset, wr, rd, quench_in, err_push, shift_menu_pin;
	logic panel_lock, remote_mark;
	logic [7:0] addr, status_in, stb;
	logic [31:0] wdata, rdata, q;
	logic signed [15:0] err_code;
	logic [2:0] range_pin;
	logic [4:0] supply_type_pin;
	logic signed [31:0] current_req, current_cmd;
	bit ok;
	int bad_count, compares;
	sasc_row_t rows [15];
	// long tick so the clock does not roll during the table
	sasc_top #(.SEC_CYCLES(100000)) u_sasc_top (.clk_sys(clk_sys),
		.reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .status_in(status_in), .quench_in(quench_in),
		.err_push(err_push), .err_code(err_code), .range_pin(range_pin),
		.supply_type_pin(supply_type_pin), .shift_menu_pin(shift_menu_pin),
		.current_req(current_req), .current_cmd(current_cmd),
		.panel_lock(panel_lock), .remote_mark(remote_mark), .stb(stb));
	sasc_host u_sasc_host (.clk_sys(clk_sys), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata));
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// ==========
	// helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic close_out();
		$display("compares=%0d bad_count=%0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// a lost answer counts as a mismatch and ends the run
	task automatic ask(input logic [7:0] op, input logic s = 1'b0);
		u_sasc_host.ask(op, s, 32'h0, q, ok);
		if (!ok) begin
			bad_count++;
			close_out();
		end
	endtask
	task automatic go(input logic [7:0] op, input logic [31:0] arg = 0);
		u_sasc_host.cmd(op, 1'b0, arg);
		repeat (5) @(posedge clk_sys);
	endtask
	task automatic st();
		u_sasc_host.xfer(1'b0, sasc_pkg::REG_STATUS, 32'h0, q);
	endtask
	// ==========
	// main sequence
	initial begin
		reset = 1'b1;
		{quench_in, err_push, shift_menu_pin, status_in, err_code} = 0;
		current_req = 0;
		range_pin = 3'h5;
		supply_type_pin = 5'h11;
		rows = '{
			'{sasc_pkg::OP_ESR_Q, 0, 0, 1, 32'h80},
			'{sasc_pkg::OP_ESR_Q, 0, 0, 1, 32'h0},
			'{sasc_pkg::OP_TST, 0, 0, 1, 32'h1},
			'{sasc_pkg::OP_IDN, 0, 0, 1,
				{sasc_pkg::MODEL_CODE, sasc_pkg::FW_REV}},
			'{sasc_pkg::OP_OPC_Q, 1, 0, 1, 32'h1},
			'{sasc_pkg::OP_SRE_SET, 0, 4, 0, 0},
			'{sasc_pkg::OP_SRE_Q, 0, 0, 1, 32'h4},
			'{sasc_pkg::OP_ESE_SET, 0, 60, 0, 0},
			'{sasc_pkg::OP_ESE_Q, 0, 0, 1, 32'h3c},
			'{sasc_pkg::OP_PSC_Q, 0, 0, 1, 32'h1},
			'{sasc_pkg::OP_MODE_Q, 0, 0, 1, 32'h5},
			'{sasc_pkg::OP_TYPE_Q, 0, 0, 1, 32'h11},
			'{sasc_pkg::OP_TIME_SET, 0, 32'h17efa, 0, 0},
			'{sasc_pkg::OP_TIME_Q, 0, 0, 1, 32'h17efa},
			'{sasc_pkg::OP_ESR_Q, 0, 0, 1, 32'h0}};
		repeat (4) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		u_sasc_host.xfer(1'b1, sasc_pkg::REG_DATE, 32'h0c1f07e8, q);
		foreach (rows[i]) begin
			u_sasc_host.ask(rows[i].op, rows[i].s, rows[i].arg, q, ok);
			if (rows[i].ans) begin
				chk(q, rows[i].exp);
				chk(32'(ok), 32'h1);
			end
		end
		u_sasc_host.xfer(1'b0, sasc_pkg::REG_DATE, 32'h0, q);
		chk(q, 32'h0c1f07e8);
		// lockout and two of the ways out of it, local and shift-menu
		go(sasc_pkg::OP_REMOTE);
		chk({remote_mark, panel_lock}, 2'b11);
		go(sasc_pkg::OP_LOCAL);
		chk(panel_lock, 1'b0);
		go(sasc_pkg::OP_REMOTE);
		shift_menu_pin <= 1'b1;
		repeat (6) @(posedge clk_sys);
		shift_menu_pin <= 1'b0;
		chk(panel_lock, 1'b0);
		// quench feeds the summary; the status query leaves it set
		quench_in <= 1'b1;
		ask(sasc_pkg::OP_STB_Q);
		chk(q, 32'h44);
		chk(stb[6], 1'b1);
		quench_in <= 1'b0;
		go(sasc_pkg::OP_OPC);
		ask(sasc_pkg::OP_ESR_Q);
		chk(q, 32'h1);
		// eleven errors into a ten-deep buffer
		err_push <= 1'b1;
		for (int i = 1; i <= 11; i++) begin
			err_code <= 16'(-i);
			@(posedge clk_sys);
		end
		err_push <= 1'b0;
		st();
		chk(q[15:12], 4'ha);
		ask(sasc_pkg::OP_ERR_Q);
		chk(q, 32'hffffffff);
		ask(sasc_pkg::OP_ERR_Q);
		chk(q, 32'hfffffffe);
		go(sasc_pkg::OP_CLS);
		ask(sasc_pkg::OP_ERR_Q);
		chk(q, 32'h0);
		ask(sasc_pkg::OP_ESR_Q);
		chk(q, 32'h0);
		// abort empties an unread answer slot
		go(sasc_pkg::OP_TST);
		u_sasc_host.xfer(1'b1, sasc_pkg::REG_ABORT, 32'h3, q);
		st();
		chk(q[1:0], 2'b00);
		// sixth command while four wait behind a full slot is dropped
		for (int i = 0; i < 6; i++) u_sasc_host.cmd(sasc_pkg::OP_TST, 0, 0);
		st();
		chk({q[10:8], stb[5]}, 4'h9);
		// a full queue would drop the reset too: drain it one answer at a time
		for (int i = 0; i < 4; i++) begin
			u_sasc_host.xfer(1'b0, sasc_pkg::REG_RESP0, 32'h0, q);
			chk(q, 32'h1);
		end
		go(sasc_pkg::OP_RST);
		st();
		chk({q[10:8], q[1:0]}, 5'h0);
		ask(sasc_pkg::OP_ESE_Q);
		chk(q, 32'h0);
		ask(sasc_pkg::OP_ESR_Q);
		chk(q[7], 1'b1);
		// one cap serves both polarities
		go(sasc_pkg::OP_CAP_SET, 32'd100);
		current_req <= -500;
		repeat (3) @(posedge clk_sys);
		chk(current_cmd, -32'sd100);
		current_req <= 500;
		repeat (3) @(posedge clk_sys);
		chk(current_cmd, 32'sd100);
		close_out();
	end
endmodule
